// ===== rtl/card_bus_pkg.sv
// constants for the card bus init and mode control
`default_nettype none
package card_bus_pkg;
  // operating conditions register layout
  localparam int          OCR_BUSY_BIT   = 31;
  localparam logic [30:0] OCR_FIXED_BITS = 31'h40ff8080;
  // command indices
  localparam logic [5:0]  CMD_GO_IDLE    = 6'h00;
  localparam logic [5:0]  CMD_SEND_OP    = 6'h01;
  localparam logic [5:0]  CMD_ALL_CID    = 6'h02;
  localparam logic [5:0]  CMD_SET_RCA    = 6'h03;
  localparam logic [5:0]  CMD_SET_DSR    = 6'h04;
  localparam logic [5:0]  CMD_SELECT     = 6'h07;
  localparam logic [5:0]  CMD_SWITCH     = 6'h06;
  localparam logic [5:0]  CMD_STATUS     = 6'h0d;
  localparam logic [31:0] ARG_BOOT       = 32'h0ffffffa;
  localparam logic [31:0] ARG_RESET      = 32'h00000000;
  // bus width field values
  localparam logic [1:0]  BW_1           = 2'h0;
  localparam logic [1:0]  BW_4           = 2'h1;
  localparam logic [1:0]  BW_8           = 2'h2;
  // status completion codes
  localparam logic [1:0]  CC_OK          = 2'h0;
  localparam logic [1:0]  CC_ILLEGAL     = 2'h1;
  localparam logic [1:0]  CC_NO_REG      = 2'h2;
  // timing
  localparam int          CLK_MHZ        = 100;
  localparam int          INIT_LIMIT_MS  = 1000;
  localparam int          INIT_LIMIT_CYC = INIT_LIMIT_MS * 1000 * CLK_MHZ;
  localparam int          INIT_STREAM_CLKS = 74;
  // card states
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_READY = 6'b000010,
    ST_IDENT = 6'b000100,
    ST_STBY  = 6'b001000,
    ST_TRAN  = 6'b010000,
    ST_BOOT  = 6'b100000
  } card_state_t;
endpackage : card_bus_pkg
`default_nettype wire

// ===== rtl/sync2.sv
// two flip-flop level synchroniser
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : sync2
`default_nettype wire

// ===== rtl/init_timer.sv
// power-up routine timer on mclk: busy until done or limit
`default_nettype none
module init_timer #(
  parameter int LIMIT = 100000000
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic core_done,
  output logic      done,
  output logic      timeout
);
  logic [31:0] cnt_r;
  logic        run_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      run_r   <= 1'b0;
      cnt_r   <= '0;
      done    <= 1'b0;
      timeout <= 1'b0;
    end else begin
      if (start && !run_r && !done)
        run_r <= 1'b1;
      if (run_r) begin
        cnt_r <= cnt_r + 32'h1;
        // finish forced at the limit so the timer never stays running; timeout set unless core done
        if (core_done || cnt_r >= 32'(LIMIT - 1)) begin
          run_r   <= 1'b0;
          done    <= 1'b1;
          timeout <= !core_done;
        end
      end
    end
  end
endmodule : init_timer
`default_nettype wire

// ===== rtl/card_bus_ctrl.sv
// card-side bus init, identification and mode control
`default_nettype none
// Contract
// - command line open-drain at init, push-pull later
// - data on line zero only after reset
// - drop unused data pull-ups on bus widening
// - power-up done within one second of op command
// - boot via held-low command or boot argument
// - boot data area chosen by configuration
// - support reset, voltage check, identify, address
// - data transfer mode once address assigned
// - select with own address enters transfer
// - push-pull on all lines from standby
// - device never starts a transaction
// - registers reached only through commands
// - driver stage register not implemented
// - status holds state and completion code
// - host writes to operating conditions ignored
// - operating conditions fixed voltage and sector bits
// - active-low coding for restricted and busy
// - busy bit low until power-up done
module card_bus_ctrl
  import card_bus_pkg::*;
#(
  parameter int INIT_LIMIT = INIT_LIMIT_CYC
) (
  // system
  input  wire logic        mclk,
  input  wire logic        rst,
  // link clock and pins
  input  wire logic        link_clk,
  input  wire logic        cmd_in,
  output logic             cmd_out,
  output logic             cmd_oe,
  output logic             cmd_push_pull,
  output logic [7:0]       dat_pullup_en,
  // decoded command from the link deserialiser
  input  wire logic        cmd_valid,
  input  wire logic [5:0]  cmd_index,
  input  wire logic [31:0] cmd_arg,
  // core side
  input  wire logic        core_init_done,
  input  wire logic        boot_from_user,
  output logic             boot_active,
  output logic             boot_user_area,
  output logic [1:0]       bus_width,
  output logic [15:0]      rca,
  output logic [5:0]       card_state,
  output logic [1:0]       last_code,
  output logic [31:0]      operating_conditions_register,
  output logic             init_timeout,
  // response toward the link
  output logic             resp_valid,
  output logic [31:0]      resp_arg
);
  // link domain: command stream capture
  logic [7:0]  lk_ones_r;
  logic        lk_stream_ok_r;
  logic        lk_low_r;
  logic        lk_tog_r;
  logic [5:0]  lk_idx_r;
  logic [31:0] lk_arg_r;
  logic        lk_held_low_r;
  // mclk domain
  logic        tog_s;
  logic        tog_d_r;
  logic        stream_ok_s;
  logic        held_low_s;
  logic        cmd_ev;
  card_state_t st_r;
  logic        op_started_r;
  logic        pu_done;
  logic        pu_timeout;
  logic        pu_ready;
  logic [15:0] rca_r;
  logic [1:0]  bw_r;
  logic [1:0]  code_r;
  logic        resp_r;
  logic [31:0] resp_arg_r;
  logic        boot_r;
  logic        boot_user_r;

  // host's 74-clock run of ones is seen on the link clock
  always_ff @(posedge link_clk) begin
    if (rst) begin
      lk_ones_r      <= '0;
      lk_stream_ok_r <= 1'b0;
      lk_low_r       <= 1'b0;
      lk_held_low_r  <= 1'b0;
    end else begin
      lk_low_r <= !cmd_in;
      if (cmd_in && lk_ones_r < 8'(INIT_STREAM_CLKS))
        lk_ones_r <= lk_ones_r + 8'h1;
      if (lk_ones_r == 8'(INIT_STREAM_CLKS))
        lk_stream_ok_r <= 1'b1;
      // held low straight after the init stream asks for boot
      if (lk_stream_ok_r && lk_low_r && !cmd_in)
        lk_held_low_r <= 1'b1;
      else if (cmd_in)
        lk_held_low_r <= 1'b0;
    end
  end

  // command words cross by toggle; data held stable until next command
  always_ff @(posedge link_clk) begin
    if (rst) begin
      lk_tog_r <= 1'b0;
      lk_idx_r <= '0;
      lk_arg_r <= '0;
    end else if (cmd_valid) begin
      lk_tog_r <= !lk_tog_r;
      lk_idx_r <= cmd_index;
      lk_arg_r <= cmd_arg;
    end
  end

  sync2 #(.W(3)) u_sync (
    .clk (mclk),
    .rst (rst),
    .d   ({lk_tog_r, lk_stream_ok_r, lk_held_low_r}),
    .q   ({tog_s, stream_ok_s, held_low_s})
  );

  always_ff @(posedge mclk) begin
    if (rst)
      tog_d_r <= 1'b0;
    else
      tog_d_r <= tog_s;
  end
  // bus is host driven: work only starts on a received command
  assign cmd_ev = tog_s ^ tog_d_r;

  init_timer #(.LIMIT(INIT_LIMIT)) u_timer (
    .clk       (mclk),
    .rst       (rst),
    .start     (op_started_r),
    .core_done (core_init_done),
    .done      (pu_done),
    .timeout   (pu_timeout)
  );

  // a timed-out routine never reports ready: the core is not done
  assign pu_ready = pu_done && !pu_timeout;

  // first op command with a valid range starts the one-second clock
  always_ff @(posedge mclk) begin
    if (rst)
      op_started_r <= 1'b0;
    else if (cmd_ev && lk_idx_r == CMD_SEND_OP && st_r == ST_IDLE
             && (lk_arg_r[23:15] != 9'h0 || lk_arg_r[7]))
      op_started_r <= 1'b1;
  end

  // card state machine
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r   <= ST_IDLE;
      rca_r  <= '0;
      code_r <= CC_OK;
    end else begin
      if (held_low_s && st_r == ST_IDLE && stream_ok_s)
        st_r <= ST_BOOT;
      else if (st_r == ST_BOOT && !held_low_s
               && !(cmd_ev && lk_idx_r == CMD_GO_IDLE))
        st_r <= held_low_s ? ST_BOOT : st_r;
      if (cmd_ev) begin
        code_r <= CC_OK;
        case (lk_idx_r)
          CMD_GO_IDLE: begin
            if (lk_arg_r == ARG_BOOT && st_r == ST_IDLE)
              st_r <= ST_BOOT;
            else if (lk_arg_r == ARG_RESET)
              st_r <= ST_IDLE;
          end
          CMD_SEND_OP: begin
            // register content fixed; host values only gate the range
            if (st_r == ST_IDLE && pu_ready)
              st_r <= ST_READY;
          end
          CMD_ALL_CID: begin
            if (st_r == ST_READY)
              st_r <= ST_IDENT;
          end
          CMD_SET_RCA: begin
            if (st_r == ST_IDENT) begin
              rca_r <= lk_arg_r[31:16];
              st_r  <= ST_STBY;
            end
          end
          CMD_SELECT: begin
            if (st_r == ST_STBY && lk_arg_r[31:16] == rca_r)
              st_r <= ST_TRAN;
            else if (st_r == ST_TRAN && lk_arg_r[31:16] != rca_r)
              st_r <= ST_STBY;
          end
          CMD_SET_DSR: code_r <= CC_NO_REG;
          CMD_SWITCH, CMD_STATUS: ;
          default: code_r <= CC_ILLEGAL;
        endcase
      end
    end
  end

  // bus width set by switch command in transfer state
  always_ff @(posedge mclk) begin
    if (rst)
      bw_r <= BW_1;
    else if (cmd_ev && lk_idx_r == CMD_SWITCH && st_r == ST_TRAN)
      bw_r <= lk_arg_r[1:0];
  end

  // boot area captured at entry, configuration steers the source
  always_ff @(posedge mclk) begin
    if (rst) begin
      boot_r      <= 1'b0;
      boot_user_r <= 1'b0;
    end else begin
      boot_r <= (st_r == ST_BOOT);
      if (st_r != ST_BOOT)
        boot_user_r <= boot_from_user;
    end
  end

  // responses only ever answer a command
  always_ff @(posedge mclk) begin
    if (rst) begin
      resp_r     <= 1'b0;
      resp_arg_r <= '0;
    end else begin
      resp_r <= cmd_ev;
      if (cmd_ev) begin
        case (lk_idx_r)
          CMD_SEND_OP: resp_arg_r <= operating_conditions_register;
          CMD_SET_DSR: resp_arg_r <= '0;
          default:     resp_arg_r <= {20'h0, 2'(code_r), 4'h0, st_r};
        endcase
      end
    end
  end

  // fixed fields plus busy, low means busy
  assign operating_conditions_register =
    {pu_ready, OCR_FIXED_BITS};

  // pin mode: open-drain until standby
  always_comb begin
    cmd_push_pull = (st_r == ST_STBY) || (st_r == ST_TRAN);
    cmd_out = 1'b1;
    cmd_oe  = 1'b0;
    // pull-ups: 4-bit drops 1,2; 8-bit drops 1,2,4-7
    case (bw_r)
      BW_4:    dat_pullup_en = 8'hf9;
      BW_8:    dat_pullup_en = 8'h09;
      default: dat_pullup_en = 8'hff;
    endcase
  end

  assign boot_active    = boot_r;
  assign boot_user_area = boot_user_r;
  assign bus_width      = bw_r;
  assign rca            = rca_r;
  assign card_state     = st_r;
  assign last_code      = code_r;
  assign init_timeout   = pu_timeout;
  assign resp_valid     = resp_r;
  assign resp_arg       = resp_arg_r;
endmodule : card_bus_ctrl
`default_nettype wire

// ===== sim/card_bus_ctrl_asserts.sv
// port assertions for the card bus control block
`default_nettype none
module card_bus_ctrl_asserts
  import card_bus_pkg::*;
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // pins
  input wire logic        cmd_oe,
  input wire logic        cmd_push_pull,
  input wire logic [7:0]  dat_pullup_en,
  // state
  input wire logic        boot_active,
  input wire logic        boot_user_area,
  input wire logic [1:0]  bus_width,
  input wire logic [15:0] rca,
  input wire logic [5:0]  card_state,
  input wire logic [31:0] operating_conditions_register,
  input wire logic        resp_valid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic [31:0] operating_conditions = operating_conditions_register;

  a_ocr_fixed: assert property (operating_conditions[30:0] == OCR_FIXED_BITS)
    else $error("fixed ocr field wrong");
  a_busy_sticky: assert property (operating_conditions[31] |=> operating_conditions[31])
    else $error("ready bit dropped");
  a_pp_mode: assert property (
    cmd_push_pull == (card_state inside {ST_STBY, ST_TRAN}))
    else $error("push-pull mode wrong");
  // pull-ups decode the width register combinationally; checked while it is stable
  a_pull_map: assert property ($stable(bus_width) |->
    dat_pullup_en == (bus_width == BW_4 ? 8'hf9 :
                      bus_width == BW_8 ? 8'h09 : 8'hff))
    else $error("pull-up set wrong");
  a_no_drive: assert property (!cmd_oe)
    else $error("command line driven");
  a_resp_pulse: assert property (resp_valid |=> !resp_valid)
    else $error("response longer than one cycle");
  a_boot_flag: assert property (card_state == ST_BOOT |=> boot_active)
    else $error("boot not flagged");
  a_boot_area: assert property (
    boot_active && $past(boot_active) |-> $stable(boot_user_area))
    else $error("boot area moved");
  a_tran_rca: assert property (card_state == ST_TRAN |-> rca != 16'h0)
    else $error("transfer without address");
endmodule : card_bus_ctrl_asserts

bind card_bus_ctrl card_bus_ctrl_asserts chk (
  .mclk, .rst, .cmd_oe, .cmd_push_pull, .dat_pullup_en, .boot_active,
  .boot_user_area, .bus_width, .rca, .card_state,
  .operating_conditions_register, .resp_valid);
`default_nettype wire

// ===== sim/host_model.sv
// host model: gated link clock and decoded commands
`default_nettype none
module host_model (
  // link toward the card
  output logic        link_clk,
  output logic        cmd_in,
  output logic        cmd_valid,
  output logic [5:0]  cmd_index,
  output logic [31:0] cmd_arg
);
  timeunit 1ns;
  timeprecision 100ps;
  logic run = 1'b1;
  initial begin
    link_clk = 1'b0;
    cmd_in = 1'b1;
    cmd_valid = 1'b0;
    cmd_index = 6'h3f;
    cmd_arg = 32'h0;
  end
  // clock stops low between frames
  always #32 if (run || link_clk) link_clk = ~link_clk;
  task automatic clocks(input int n);
    run = 1'b1;
    repeat (n) @(posedge link_clk);
    run = 1'b0;
  endtask : clocks
  // command line held low after the init stream asks for boot
  task automatic hold_low(input int n);
    run = 1'b1;
    @(posedge link_clk);
    cmd_in <= 1'b0;
    repeat (n) @(posedge link_clk);
    cmd_in <= 1'b1;
    repeat (3) @(posedge link_clk);
    run = 1'b0;
  endtask : hold_low
  task automatic send(input logic [5:0] idx, input logic [31:0] arg);
    run = 1'b1;
    @(posedge link_clk);
    cmd_valid <= 1'b1;
    cmd_index <= idx;
    cmd_arg <= arg;
    @(posedge link_clk);
    cmd_valid <= 1'b0;
    // released fields must not look like the last command
    cmd_index <= ~idx;
    cmd_arg <= ~arg;
    repeat (3) @(posedge link_clk);
    run = 1'b0;
  endtask : send
endmodule : host_model
`default_nettype wire

// ===== sim/card_bus_ctrl_tb.sv
// self-checking bench for card bus init and mode control
`default_nettype none
module card_bus_ctrl_tb
  import card_bus_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        core_init_done = 1'b0;
  logic        boot_from_user = 1'b0;
  logic        link_clk, cmd_in, cmd_valid, cmd_push_pull, resp_valid;
  logic        boot_active, boot_user_area, init_timeout;
  logic [5:0]  cmd_index, card_state;
  logic [31:0] cmd_arg, operating_conditions, resp_arg;
  logic [1:0]  bus_width, last_code;
  logic [7:0]  dat_pullup_en;
  logic [15:0] rca;
  logic [1:0]  widths [3] = '{BW_4, BW_8, BW_1};
  logic [7:0]  pulls [3] = '{8'hf9, 8'h09, 8'hff};
  int          err_count = 0;
  int          compares = 0;

  always #5 mclk = ~mclk;

  card_bus_ctrl #(.INIT_LIMIT(200)) uut (
    .mclk, .rst, .link_clk, .cmd_in, .cmd_out(), .cmd_oe(), .cmd_push_pull,
    .dat_pullup_en, .cmd_valid, .cmd_index, .cmd_arg, .core_init_done,
    .boot_from_user, .boot_active, .boot_user_area, .bus_width, .rca,
    .card_state, .last_code, .operating_conditions_register(operating_conditions),
    .init_timeout, .resp_valid, .resp_arg);
  host_model host (.link_clk, .cmd_in, .cmd_valid, .cmd_index, .cmd_arg);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  // the send outlasts the response, so wait on both
  task automatic cmd(input logic [5:0] idx, input logic [31:0] arg);
    int n;
    n = 0;
    fork
      host.send(idx, arg);
      while (resp_valid !== 1'b1 && n < 60) begin
        @(negedge mclk);
        n++;
      end
    join
  endtask : cmd
  task automatic do_reset();
    fork
      host.clocks(80);
      begin
        @(posedge mclk) rst <= 1'b1;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
      end
    join
  endtask : do_reset

  initial begin
    #100000;
    err_count++;
    test_done();
  end

  initial begin
    do_reset();
    chk(card_state, ST_IDLE);
    chk(dat_pullup_en, 8'hff);
    chk(operating_conditions, {1'b0, OCR_FIXED_BITS});
    cmd(CMD_GO_IDLE, ARG_RESET);
    cmd(CMD_SEND_OP, 32'h00ff8080);
    chk(operating_conditions[31], 1'b0);
    @(posedge mclk) core_init_done <= 1'b1;
    cmd(CMD_SEND_OP, 32'hffffffff);
    chk(operating_conditions, {1'b1, OCR_FIXED_BITS});
    chk(resp_arg, {1'b1, OCR_FIXED_BITS});
    chk(card_state, ST_READY);
    cmd(CMD_SET_DSR, 32'h0);
    chk(last_code, CC_NO_REG);
    cmd(6'h3f, 32'h0);
    chk(last_code, CC_ILLEGAL);
    cmd(CMD_ALL_CID, 32'h0);
    chk(card_state, ST_IDENT);
    cmd(CMD_SET_RCA, 32'h5a3c0000);
    chk(rca, 16'h5a3c);
    chk(card_state, ST_STBY);
    chk(cmd_push_pull, 1'b1);
    cmd(CMD_SELECT, 32'h5a3d0000);
    chk(card_state, ST_STBY);
    cmd(CMD_SELECT, 32'h5a3c0000);
    chk(card_state, ST_TRAN);
    foreach (pulls[i]) begin
      cmd(CMD_SWITCH, {30'h0, widths[i]});
      chk(bus_width, widths[i]);
      chk(dat_pullup_en, pulls[i]);
    end
    cmd(CMD_STATUS, 32'h5a3c0000);
    chk(resp_arg, {20'h0, CC_OK, 4'h0, ST_TRAN});
    @(posedge mclk) boot_from_user <= 1'b1;
    do_reset();
    cmd(CMD_GO_IDLE, ARG_BOOT);
    chk(card_state, ST_BOOT);
    chk(boot_active, 1'b1);
    @(posedge mclk) boot_from_user <= 1'b0;
    repeat (3) @(negedge mclk);
    chk(boot_user_area, 1'b1);
    @(posedge mclk) core_init_done <= 1'b0;
    do_reset();
    cmd(CMD_SEND_OP, 32'h00008080);
    repeat (250) @(negedge mclk);
    chk(init_timeout, 1'b1);
    chk(operating_conditions[31], 1'b0);
    do_reset();
    host.hold_low(4);
    repeat (10) @(negedge mclk);
    chk(card_state, ST_BOOT);
    chk(boot_active, 1'b1);
    test_done();
  end
endmodule : card_bus_ctrl_tb
`default_nettype wire
